// ---- rtl/isf_cfg.svh ----
// Offsets, field positions, reset values and event indices of the status flags
`ifndef ISF_CFG_SVH
`define ISF_CFG_SVH

// ----------------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------------
`define ISF_ADDR_W 4
`define ISF_DATA_W 16
`define ISF_OFS_STATUS 4'h0
`define ISF_OFS_TXBUF 4'h1
`define ISF_OFS_RXBUF 4'h2

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define ISF_BIT_ACK 15
`define ISF_BIT_TXACT 14
`define ISF_BIT_COLL 10
`define ISF_BIT_GC 9
`define ISF_BIT_TEN 8
`define ISF_BIT_WCOL 7
`define ISF_BIT_OV 6
`define ISF_BIT_DA 5
`define ISF_BIT_STOP 4
`define ISF_BIT_START 3
`define ISF_BIT_RBF 1
`define ISF_STATUS_RST 16'h0000
`define ISF_BYTE_RST 8'h00

// ----------------------------------------------------------------------------
// Link events, one toggle each
// ----------------------------------------------------------------------------
`define ISF_EVT_N 8
`define ISF_EV_TXSTART 0
`define ISF_EV_ACKEND 1
`define ISF_EV_COLL 2
`define ISF_EV_GC 3
`define ISF_EV_TEN 4
`define ISF_EV_STOP 5
`define ISF_EV_START 6
`define ISF_EV_BYTE 7

`endif

// ---- rtl/isf_pkg.sv ----
// Types shared by the status flag block
package isf_pkg;
  `include "isf_cfg.svh"

  typedef logic [7:0] isf_byte_t;
  typedef logic [`ISF_DATA_W-1:0] isf_word_t;
  typedef logic [`ISF_EVT_N-1:0] isf_evt_t;
endpackage : isf_pkg

// ---- rtl/isf_evt_if.sv ----
// Link-to-core event carrier: toggles plus held data
`timescale 1ns/10ps
interface isf_evt_if;
  import isf_pkg::*;
  isf_evt_t toggle;
  logic ack_nack;
  isf_byte_t rx_byte;
  logic rx_is_data;

  modport link (output toggle, output ack_nack, output rx_byte,
    output rx_is_data);
  modport core (input toggle, input ack_nack, input rx_byte,
    input rx_is_data);
endinterface : isf_evt_if

// ---- rtl/isf_link_events.sv ----
// Link clock side: turns event pulses into toggles and holds their data
`timescale 1ns/10ps
`include "isf_cfg.svh"
module isf_link_events
  import isf_pkg::*;
(
  // Carrier to the core domain
  isf_evt_if.link evt,
  // Link clock and reset
  input wire logic link_clk,
  input wire logic link_srst,
  // Event pulses from the shift engine and bus detectors
  input wire isf_evt_t evt_pulse,
  input wire logic ack_nack,
  input wire isf_byte_t rx_byte,
  input wire logic rx_is_data
);

  // --------------------------------------------------------------------------
  // One toggle per event
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `ISF_EVT_N; gi = gi + 1) begin : g_tog
      always_ff @(posedge link_clk) begin
        if (link_srst) begin
          evt.toggle[gi] <= 1'b0;
        end else if (evt_pulse[gi]) begin
          evt.toggle[gi] <= ~evt.toggle[gi];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Held data, stable until the next event of its kind
  // --------------------------------------------------------------------------
  // Core reads these only after the toggle has crossed, so they are settled
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      evt.ack_nack <= 1'b0;
    end else if (evt_pulse[`ISF_EV_ACKEND]) begin
      evt.ack_nack <= ack_nack;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      evt.rx_byte <= `ISF_BYTE_RST;
      evt.rx_is_data <= 1'b0;
    end else if (evt_pulse[`ISF_EV_BYTE]) begin
      evt.rx_byte <= rx_byte;
      evt.rx_is_data <= rx_is_data;
    end
  end

endmodule : isf_link_events

// ---- rtl/isf_status_flags.sv ----
// Status flag logic of the I2C controller with its register port
//
// Overview of operation
// - At end of slave acknowledge, ack result bit 15 = 1 for NACK, 0 for ACK.
// - Master transmit active bit 14 sets when a master transmission begins.
// - Master transmit active clears once the slave acknowledge period ends.
// - Bus collision bit 10 sets on any collision event, whether or not master transmit is active.
// - General call bit 9 sets on general call match, clears on stop.
// - Ten-bit match bit 8 sets on second address byte match, clears on stop.
// - Transmit buffer write while busy is refused; sets bit 7 until cleared.
// - Byte into full receive buffer sets overflow bit 6; software clears it.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "isf_cfg.svh"
module isf_status_flags
  import isf_pkg::*;
(
  // Core clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [`ISF_ADDR_W-1:0] addr,
  input wire isf_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output isf_word_t rdata,
  // Link clock and reset
  input wire logic link_clk,
  input wire logic link_srst,
  // Link events, one-cycle pulses on link_clk
  input wire logic tx_start,
  input wire logic ack_end,
  input wire logic ack_nack,
  input wire logic collision,
  input wire logic gc_match,
  input wire logic ten_match,
  input wire logic stop_seen,
  input wire logic start_seen,
  input wire logic byte_done,
  input wire isf_byte_t rx_byte,
  input wire logic rx_is_data,
  // Transmit buffer towards the shift engine
  output isf_byte_t tx_data,
  output logic tx_load
);

  // --------------------------------------------------------------------------
  // Link domain and crossing
  // --------------------------------------------------------------------------
  isf_evt_if evt ();
  isf_evt_t link_pulse;
  isf_evt_t tog_meta;
  isf_evt_t tog_sync;
  isf_evt_t tog_prev;
  isf_evt_t ev;

  assign link_pulse = {byte_done, start_seen, stop_seen, ten_match,
    gc_match, collision, ack_end, tx_start};

  isf_link_events u_link (
    .evt(evt.link),
    .link_clk(link_clk),
    .link_srst(link_srst),
    .evt_pulse(link_pulse),
    .ack_nack(ack_nack),
    .rx_byte(rx_byte),
    .rx_is_data(rx_is_data)
  );

  // Both resets drop together, else a cleared toggle reads as an event
  // Three flops per toggle, edge taken from the second and third only
  genvar gi;
  generate
    for (gi = 0; gi < `ISF_EVT_N; gi = gi + 1) begin : g_sync
      always_ff @(posedge clock) begin
        if (srst) begin
          tog_meta[gi] <= 1'b0;
          tog_sync[gi] <= 1'b0;
          tog_prev[gi] <= 1'b0;
        end else begin
          tog_meta[gi] <= evt.toggle[gi];
          tog_sync[gi] <= tog_meta[gi];
          tog_prev[gi] <= tog_sync[gi];
        end
      end
      assign ev[gi] = tog_sync[gi] ^ tog_prev[gi];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  logic wr_status;
  logic wr_txbuf;
  logic rd_rxbuf;
  logic rd_status;
  logic rd_txbuf;

  // Read and write strobes never meet, so each decode stands alone
  assign wr_status = wr && (addr == `ISF_OFS_STATUS);
  assign wr_txbuf = wr && (addr == `ISF_OFS_TXBUF);
  assign rd_rxbuf = rd && (addr == `ISF_OFS_RXBUF);
  assign rd_status = rd && (addr == `ISF_OFS_STATUS);
  assign rd_txbuf = rd && (addr == `ISF_OFS_TXBUF);

  // --------------------------------------------------------------------------
  // Master transmit flags
  // --------------------------------------------------------------------------
  logic ack_result_flag;
  logic master_tx_active_flag;

  // Held ack value settles on the same link edge that moves its toggle
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_result_flag <= 1'b0;
    end else if (ev[`ISF_EV_ACKEND]) begin
      ack_result_flag <= evt.ack_nack;
    end
  end

  // Start of a new byte wins over the end of the previous acknowledge
  always_ff @(posedge clock) begin
    if (srst) begin
      master_tx_active_flag <= 1'b0;
    end else if (ev[`ISF_EV_TXSTART]) begin
      master_tx_active_flag <= 1'b1;
    end else if (ev[`ISF_EV_ACKEND]) begin
      master_tx_active_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Software-cleared flags: write 0 to clear, hardware set wins
  // --------------------------------------------------------------------------
  // Writing 1 keeps a flag, so one write can clear a single bit
  logic bus_collision_flag;
  logic transmit_write_collision_flag;
  logic receive_overflow_flag;
  logic rx_full;
  logic ov_hit;

  // A read in the same cycle as a new byte frees the buffer first
  assign ov_hit = ev[`ISF_EV_BYTE] && rx_full && !rd_rxbuf;

  always_ff @(posedge clock) begin
    if (srst) begin
      bus_collision_flag <= 1'b0;
    end else if (ev[`ISF_EV_COLL]) begin
      bus_collision_flag <= 1'b1;
    end else if (wr_status && !wdata[`ISF_BIT_COLL]) begin
      bus_collision_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      transmit_write_collision_flag <= 1'b0;
    end else if (wr_txbuf && master_tx_active_flag) begin
      transmit_write_collision_flag <= 1'b1;
    end else if (wr_status && !wdata[`ISF_BIT_WCOL]) begin
      transmit_write_collision_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      receive_overflow_flag <= 1'b0;
    end else if (ov_hit) begin
      receive_overflow_flag <= 1'b1;
    end else if (wr_status && !wdata[`ISF_BIT_OV]) begin
      receive_overflow_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Address match flags, cleared by stop
  // --------------------------------------------------------------------------
  logic general_call_flag;
  logic ten_bit_match_flag;

  // A match landing with a stop belongs to the next transfer
  always_ff @(posedge clock) begin
    if (srst) begin
      general_call_flag <= 1'b0;
    end else if (ev[`ISF_EV_GC]) begin
      general_call_flag <= 1'b1;
    end else if (ev[`ISF_EV_STOP]) begin
      general_call_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ten_bit_match_flag <= 1'b0;
    end else if (ev[`ISF_EV_TEN]) begin
      ten_bit_match_flag <= 1'b1;
    end else if (ev[`ISF_EV_STOP]) begin
      ten_bit_match_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Bus condition and byte type flags
  // --------------------------------------------------------------------------
  logic data_flag;
  logic stop_flag;
  logic start_flag;

  // An overflowed byte still counts as the last byte on the bus
  always_ff @(posedge clock) begin
    if (srst) begin
      data_flag <= 1'b0;
    end else if (ev[`ISF_EV_BYTE]) begin
      data_flag <= evt.rx_is_data;
    end
  end

  // Stop wins if both crossed in one cycle: stop is the safer view
  always_ff @(posedge clock) begin
    if (srst) begin
      stop_flag <= 1'b0;
      start_flag <= 1'b0;
    end else if (ev[`ISF_EV_STOP]) begin
      stop_flag <= 1'b1;
      start_flag <= 1'b0;
    end else if (ev[`ISF_EV_START]) begin
      stop_flag <= 1'b0;
      start_flag <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Receive buffer
  // --------------------------------------------------------------------------
  isf_byte_t receive_buffer_reg;

  // On overflow the held byte is kept and the new one is lost
  always_ff @(posedge clock) begin
    if (srst) begin
      receive_buffer_reg <= `ISF_BYTE_RST;
      rx_full <= 1'b0;
    end else if (ev[`ISF_EV_BYTE] && !ov_hit) begin
      receive_buffer_reg <= evt.rx_byte;
      rx_full <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_full <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Transmit buffer
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_data <= `ISF_BYTE_RST;
      tx_load <= 1'b0;
    end else begin
      // Busy: a byte is on the wire, so a refused byte never reaches it
      tx_load <= wr_txbuf && !master_tx_active_flag;
      if (wr_txbuf && !master_tx_active_flag) begin
        tx_data <= wdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  isf_word_t bus_status_reg;

  always_comb begin
    bus_status_reg = `ISF_STATUS_RST;
    bus_status_reg[`ISF_BIT_ACK] = ack_result_flag;
    bus_status_reg[`ISF_BIT_TXACT] = master_tx_active_flag;
    bus_status_reg[`ISF_BIT_COLL] = bus_collision_flag;
    bus_status_reg[`ISF_BIT_GC] = general_call_flag;
    bus_status_reg[`ISF_BIT_TEN] = ten_bit_match_flag;
    bus_status_reg[`ISF_BIT_WCOL] = transmit_write_collision_flag;
    bus_status_reg[`ISF_BIT_OV] = receive_overflow_flag;
    bus_status_reg[`ISF_BIT_DA] = data_flag;
    bus_status_reg[`ISF_BIT_STOP] = stop_flag;
    bus_status_reg[`ISF_BIT_START] = start_flag;
    bus_status_reg[`ISF_BIT_RBF] = rx_full;
  end

  // Unmapped or idle reads give zero
  // Read data stand for one cycle only, the one after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= `ISF_STATUS_RST;
    end else if (rd_status) begin
      rdata <= bus_status_reg;
    end else if (rd_rxbuf) begin
      rdata <= {8'h00, receive_buffer_reg};
    end else if (rd_txbuf) begin
      rdata <= {8'h00, tx_data};
    end else begin
      rdata <= `ISF_STATUS_RST;
    end
  end

endmodule : isf_status_flags

// ---- testbench/isf_status_chk.sv ----
// Port checks of the status flag block
`timescale 1ns/10ps
`include "isf_cfg.svh"
module isf_status_chk
  import isf_pkg::*;
(
  // Core side
  input wire logic clock,
  input wire logic srst,
  input wire logic [`ISF_ADDR_W-1:0] addr,
  input wire isf_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire isf_word_t rdata,
  input wire isf_byte_t tx_data,
  input wire logic tx_load
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);

  a_unused_zero: assert property (
    rdata[13:11] == 3'h0) else $error("unused bits set");
  a_rdata_idle: assert property (
    (!$past(rd) || $past(addr) > 4'h2) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  a_load_cause: assert property (
    tx_load |-> $past(wr) && $past(addr) == `ISF_OFS_TXBUF &&
    tx_data == $past(wdata[7:0])) else $error("load without write");
  a_data_hold: assert property (
    !tx_load |-> $stable(tx_data)) else $error("tx buffer moved");
  a_rx_upper: assert property (
    $past(rd) && $past(addr) == `ISF_OFS_RXBUF |-> rdata[15:8] == 8'h00)
    else $error("rx upper bits set");
  a_stop_start: assert property (
    $past(rd) && $past(addr) == `ISF_OFS_STATUS |-> !(rdata[4] && rdata[3]))
    else $error("stop and start both shown");
  a_wcol_clear: assert property (
    (wr && addr == `ISF_OFS_STATUS && !wdata[7]) ##1
    (rd && addr == `ISF_OFS_STATUS) |=> !rdata[7])
    else $error("write collision not cleared");
  a_flags_sticky: assert property (
    (rd && addr == `ISF_OFS_STATUS) ##1 (rd && addr == `ISF_OFS_STATUS)
    |=> (rdata & $past(rdata) & 16'h04c0) == ($past(rdata) & 16'h04c0))
    else $error("sticky flag dropped");
endmodule : isf_status_chk

// ---- testbench/isf_bus_peer.sv ----
// Far-side event source: bus conditions as the link logic sees them
`timescale 1ns/10ps
module isf_bus_peer
  import isf_pkg::*;
(
  // Link clock
  input wire logic link_clk,
  // Event pulses and their data
  output isf_evt_t pulse,
  output logic ack_nack,
  output isf_byte_t rx_byte,
  output logic rx_is_data
);
  initial begin
    pulse = 8'h00;
    ack_nack = 1'b0;
    rx_byte = 8'h00;
    rx_is_data = 1'b0;
  end

  task automatic fire(input isf_evt_t ev, input logic nack,
      input isf_byte_t b, input logic dat);
    @(posedge link_clk);
    pulse <= ev;
    ack_nack <= nack;
    rx_byte <= b;
    rx_is_data <= dat;
    @(posedge link_clk);
    pulse <= 8'h00;
    // Data invalid outside its pulse: never leave a stale copy
    ack_nack <= ~nack;
    rx_byte <= ~b;
    rx_is_data <= ~dat;
    // Keeps events of one kind well apart for the synchroniser
    repeat (6) @(posedge link_clk);
  endtask : fire
endmodule : isf_bus_peer

// ---- testbench/test_isf_status_flags.sv ----
// Self-checking bench of the status flag block
`timescale 1ns/10ps
`include "isf_cfg.svh"
module test_isf_status_flags
  import isf_pkg::*;
  ;
  typedef struct {
    isf_evt_t ev;
    logic nack;
    isf_byte_t b;
    logic dat;
    isf_word_t exp;
  } isf_row_s;
  logic clock = 1'b0, srst = 1'b1, link_clk = 1'b0, link_srst = 1'b1;
  logic wr = 1'b0, rd = 1'b0, tx_load, ack_nack, rx_is_data;
  logic [3:0] addr = 4'h0;
  isf_word_t wdata = 16'h0000, rdata;
  isf_byte_t tx_data, rx_byte;
  isf_evt_t pulse;
  int err_total = 0, num_checks = 0;
  isf_row_s rows [11] = '{
    '{8'h40, 1'b0, 8'h00, 1'b0, 16'h0008},
    '{8'h01, 1'b0, 8'h00, 1'b0, 16'h4008},
    '{8'h02, 1'b1, 8'h00, 1'b0, 16'h8008},
    '{8'h01, 1'b0, 8'h00, 1'b0, 16'hc008},
    '{8'h02, 1'b0, 8'h00, 1'b0, 16'h0008},
    '{8'h04, 1'b0, 8'h00, 1'b0, 16'h0408},
    '{8'h08, 1'b0, 8'h00, 1'b0, 16'h0608},
    '{8'h10, 1'b0, 8'h00, 1'b0, 16'h0708},
    '{8'h80, 1'b0, 8'h3c, 1'b0, 16'h070a},
    '{8'h80, 1'b0, 8'ha5, 1'b0, 16'h074a},
    '{8'h20, 1'b0, 8'h00, 1'b0, 16'h0452}};

  always #25 clock = ~clock;
  always #24 link_clk = ~link_clk;

  isf_bus_peer peer (.link_clk(link_clk), .pulse(pulse), .ack_nack(ack_nack),
    .rx_byte(rx_byte), .rx_is_data(rx_is_data));
  isf_status_flags DUT (.clock(clock), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_clk(link_clk),
    .link_srst(link_srst), .tx_start(pulse[`ISF_EV_TXSTART]),
    .ack_end(pulse[`ISF_EV_ACKEND]), .ack_nack(ack_nack),
    .collision(pulse[`ISF_EV_COLL]), .gc_match(pulse[`ISF_EV_GC]),
    .ten_match(pulse[`ISF_EV_TEN]), .stop_seen(pulse[`ISF_EV_STOP]),
    .start_seen(pulse[`ISF_EV_START]), .byte_done(pulse[`ISF_EV_BYTE]),
    .rx_byte(rx_byte), .rx_is_data(rx_is_data), .tx_data(tx_data),
    .tx_load(tx_load));

  task automatic chk(input isf_word_t seen, input isf_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One bus cycle; strobe stays up until quiet or the next cycle
  task automatic acc(input logic w, input logic [3:0] a, input isf_word_t d);
    @(posedge clock);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
  endtask : acc

  task automatic quiet();
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : quiet

  task automatic rd_chk(input logic [3:0] a, input isf_word_t exp);
    acc(1'b0, a, 16'h0000);
    quiet();
    #1 chk(rdata, exp);
  endtask : rd_chk

  task automatic ev(input isf_evt_t e, input logic n);
    peer.fire(e, n, 8'h5a, 1'b1);
    repeat (4) @(posedge clock);
  endtask : ev

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    link_srst <= 1'b0;
    foreach (rows[i]) begin
      peer.fire(rows[i].ev, rows[i].nack, rows[i].b, rows[i].dat);
      repeat (4) @(posedge clock);
      rd_chk(`ISF_OFS_STATUS, rows[i].exp);
    end
    rd_chk(`ISF_OFS_RXBUF, 16'h003c);
    ev(8'h80, 1'b0);
    rd_chk(`ISF_OFS_STATUS, 16'h0472);
    rd_chk(`ISF_OFS_RXBUF, 16'h005a);
    acc(1'b1, `ISF_OFS_STATUS, 16'hffff);
    rd_chk(`ISF_OFS_STATUS, 16'h0470);
    acc(1'b1, `ISF_OFS_STATUS, 16'h0000);
    rd_chk(`ISF_OFS_STATUS, 16'h0030);
    ev(8'h01, 1'b0);
    acc(1'b1, `ISF_OFS_TXBUF, 16'h1234);
    acc(1'b0, `ISF_OFS_STATUS, 16'h0000);
    rd_chk(`ISF_OFS_STATUS, 16'h40b0);
    chk({8'h00, tx_data}, 16'h0000);
    ev(8'h02, 1'b0);
    acc(1'b1, `ISF_OFS_TXBUF, 16'h0055);
    quiet();
    #1 chk({15'h0000, tx_load}, 16'h0001);
    chk({8'h00, tx_data}, 16'h0055);
    acc(1'b1, `ISF_OFS_STATUS, 16'h0000);
    rd_chk(`ISF_OFS_STATUS, 16'h0030);
    acc(1'b1, 4'hf, 16'hffff);
    rd_chk(4'hf, 16'h0000);
    ev(8'h40, 1'b0);
    rd_chk(`ISF_OFS_STATUS, 16'h0028);
    @(posedge clock);
    srst <= 1'b1;
    link_srst <= 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    link_srst <= 1'b0;
    rd_chk(`ISF_OFS_STATUS, 16'h0000);
    rd_chk(`ISF_OFS_RXBUF, 16'h0000);
    give_verdict();
  end
endmodule : test_isf_status_flags

bind isf_status_flags isf_status_chk u_chk (.clock(clock), .srst(srst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .tx_data(tx_data), .tx_load(tx_load));
